/* File: ste_defines.svh */
`ifndef STE_DEFINES_SVH
`define STE_DEFINES_SVH

// group layout: bits 9..4 carry abcdei, bits 3..0 carry fghj
`define STE_GRP_ERR_BIT   9
`define STE_GRP_FV_BIT    8
`define STE_ENT_K_BIT     10
`define STE_K28_5_BYTE    8'hBC
`define STE_WSYNC_BYTE    8'hAD
`define STE_IDLE_RDN      10'h0FA
`define STE_IDLE_RDP      10'h305
`define STE_ILLEGAL_GROUP 10'h3E0
`define STE_WSYNC_LAST    4'hF
// bit i set: group i of the word-sync burst is the positive-disparity idle
`define STE_WSYNC_PAT_RDN 16'h00FF
`define STE_WSYNC_PAT_RDP 16'hFF00
`define STE_TX_NOMINAL_MHZ 125
`define STE_DIV_RISE_PHASE 2'h0
`define STE_DIV_FALL_PHASE 2'h2

`endif

/* File: ste_pkg.sv */
package ste_pkg;
  typedef logic [10:0] ste_entry_t;
  typedef logic [9:0]  ste_group_t;
  typedef enum {ST_NORMAL, ST_SYNC} ste_tx_state_t;
endpackage : ste_pkg

/* File: ste_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface ste_link_if;
  logic       tx_clk;
  logic [7:0] tx_byte;
  logic       tx_frame_valid;
  logic       tx_error_force;
  logic       tx_control_flag;
  modport host (
    output tx_clk,
    output tx_byte,
    output tx_frame_valid,
    output tx_error_force,
    output tx_control_flag
  );
  modport device (
    input tx_clk,
    input tx_byte,
    input tx_frame_valid,
    input tx_error_force,
    input tx_control_flag
  );
endinterface : ste_link_if
`default_nettype wire

/* File: ste_device.sv */
// Functional notes
// [RULE_01] low pin backplane, high pin Ethernet mode
// [RULE_02] bypass pin low encodes, high passes groups
// [RULE_03] double-edge pin narrows bus to 4/5 bits
// [RULE_04] capture rising edges, or both when double-edge
// [RULE_05] fifo crosses link clock into reference clock
// [RULE_06] own link clock, optionally first channel's clock
// [RULE_07] source clock same frequency, phase within half
// [RULE_08] nominal 125 MHz, one word per clock
// [RULE_09] frame-valid low sends K28.5 idle, inputs ignored
// [RULE_10] plain byte encoded as data character
// [RULE_11] control flag sends K code, else illegal
// [RULE_12] error force emits invalid ten-bit group
// [RULE_13] control AD starts sixteen-group word-sync burst
// [RULE_14] inputs ignored until burst of sixteen completes
// [RULE_15] bypass sends groups unchanged, mode pin ignored
// [RULE_16] coded group: error bit9, valid bit8, byte
// [RULE_17] coded mode ignores the control flag
// [RULE_18] foreign code keeps balance, idle, no comma
// [RULE_19] Ethernet coded modes present valid 8B/10B groups
// [RULE_20] source sends comma groups for alignment
// [RULE_21] coded mode source applies word-sync sequence
// [RULE_22] word-sync idle patterns held as constants
// [RULE_23] disparity updated after every emitted group
`timescale 1ns/1ns
`default_nettype none
`include "ste_defines.svh"
module ste_device (
  input  wire logic         clk,
  input  wire logic         rst,
  ste_link_if.device        link,
  input  wire logic         first_channel_tx_clk,
  input  wire logic         shared_clk_select,
  input  wire logic         ethernet_mode_select,
  input  wire logic         coded_bypass_enable,
  input  wire logic         double_edge_select,
  output logic [9:0]        tx_group_q,
  output logic              running_disparity_q,
  output logic              wsync_busy,
  output logic              rx_ethernet_cfg,
  output logic              rx_coded_cfg
);
  localparam logic [5:0] TAB6 [0:31] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] TAB4 [0:7] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  // returns {disparity after, group}
  function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic k, input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] c6;
    logic [3:0] c4;
    logic       rd6;
    logic       k28;
    logic       kok;
    x   = d[4:0];
    y   = d[7:5];
    k28 = k && (x == 5'h1C);
    kok = !k || k28 || ((y == 3'h7) && (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E));
    c6  = k28 ? 6'h0F : TAB6[x];
    if (rd && (($countones(c6) != 3) || (x == 5'h07)))
      c6 = ~c6;
    rd6 = ($countones(c6) != 3) ? !rd : rd;
    c4  = TAB4[y];
    if ((y == 3'h7) && (k || (!rd6 && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
        (rd6 && (x == 5'h0B || x == 5'h0D || x == 5'h0E))))
      c4 = 4'h7;
    if (rd6 && (($countones(c4) != 2) || (y == 3'h3)))
      c4 = ~c4;
    else if (k28 && !rd6 && ($countones(c4) == 2) && (y != 3'h3))
      c4 = ~c4;
    if (!kok)
      enc8b10b = {rd, `STE_ILLEGAL_GROUP}; // [RULE_11]
    else
      enc8b10b = {(($countones(c4) != 2) ? !rd6 : rd6), c6, c4};
  endfunction : enc8b10b

  // ---------------- link domain ----------------
  logic                 cap_clk;
  logic [1:0]           lcfg_meta_q;
  logic [1:0]           lcfg_q;
  logic [4:0]           fall_q;
  logic [10:0]          rise_q;
  logic                 primed_q;
  ste_pkg::ste_entry_t  mem_q [0:3];
  ste_pkg::ste_entry_t  wr_entry;
  logic [2:0]           wbin_q;
  logic [2:0]           wgray_q;
  logic [2:0]           rg_meta_q;
  logic [2:0]           rg_sync_q;
  logic                 full;
  logic [2:0]           wbin_nx;
  logic [2:0]           ste_rbin_q;
  logic [2:0]           ste_rgray_q;

  // clock select is a strap; switching it live can glitch the capture clock
  assign cap_clk = shared_clk_select ? first_channel_tx_clk : link.tx_clk; // [RULE_06]

  always_ff @(posedge cap_clk or posedge rst) begin
    if (rst) begin
      lcfg_meta_q <= 2'h0;
      lcfg_q      <= 2'h0;
    end else begin
      lcfg_meta_q <= {coded_bypass_enable, double_edge_select};
      lcfg_q      <= lcfg_meta_q;
    end
  end

  // high half of a double-edge word, 4 data bits plus the fifth on frame valid
  always_ff @(negedge cap_clk or posedge rst) begin
    if (rst)
      fall_q <= 5'h00;
    else
      fall_q <= {link.tx_frame_valid, link.tx_byte[3:0]}; // [RULE_04]
  end

  always_ff @(posedge cap_clk or posedge rst) begin
    if (rst) begin
      rise_q   <= 11'h000;
      primed_q <= 1'b0;
    end else begin
      rise_q   <= {link.tx_control_flag, link.tx_error_force, link.tx_frame_valid, link.tx_byte};
      primed_q <= 1'b1;
    end
  end

  always_comb begin
    wr_entry = {link.tx_control_flag, link.tx_error_force, link.tx_frame_valid, link.tx_byte};
    if (lcfg_q[0]) begin // [RULE_03]
      if (lcfg_q[1])
        wr_entry = {rise_q[10], fall_q, rise_q[8], rise_q[3:0]};
      else
        wr_entry = {rise_q[10:8], fall_q[3:0], rise_q[3:0]};
    end
  end

  assign full    = (wgray_q == {~rg_sync_q[2:1], rg_sync_q[0]});
  assign wbin_nx = wbin_q + 3'h1;

  // one word per rising edge; a double-edge word is written on the rising edge after its halves
  always_ff @(posedge cap_clk or posedge rst) begin
    if (rst) begin
      wbin_q  <= 3'h0;
      wgray_q <= 3'h0;
    end else if (!full && (!lcfg_q[0] || primed_q)) begin // [RULE_08]
      wbin_q  <= wbin_nx;
      wgray_q <= wbin_nx ^ (wbin_nx >> 1);
    end
  end

  always_ff @(posedge cap_clk) begin
    if (!full)
      mem_q[wbin_q[1:0]] <= wr_entry; // [RULE_05]
  end

  always_ff @(posedge cap_clk or posedge rst) begin
    if (rst) begin
      rg_meta_q <= 3'h0;
      rg_sync_q <= 3'h0;
    end else begin
      rg_meta_q <= ste_rgray_q;
      rg_sync_q <= rg_meta_q;
    end
  end

  // ---------------- reference domain ----------------
  logic [2:0]              wg_meta_q;
  logic [2:0]              wg_sync_q;
  logic [2:0]              rbin_nx;
  logic                    empty;
  logic [1:0]              cfg_meta_q;
  logic [1:0]              cfg_q;
  ste_pkg::ste_entry_t     ent;
  ste_pkg::ste_tx_state_t  state_q;
  logic [3:0]              burst_cnt_q;
  logic [15:0]             burst_pat_q;
  logic [10:0]             enc_out;
  logic [10:0]             next_out;
  logic                    start_sync;
  logic [15:0]             start_pat;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_meta_q <= 2'h0;
      cfg_q      <= 2'h0;
      wg_meta_q  <= 3'h0;
      wg_sync_q  <= 3'h0;
    end else begin
      cfg_meta_q <= {ethernet_mode_select, coded_bypass_enable};
      cfg_q      <= cfg_meta_q;
      wg_meta_q  <= wgray_q;
      wg_sync_q  <= wg_meta_q;
    end
  end

  assign rx_ethernet_cfg = cfg_q[1]; // [RULE_01]
  assign rx_coded_cfg    = cfg_q[0];
  assign empty           = (ste_rgray_q == wg_sync_q);
  assign rbin_nx         = ste_rbin_q + 3'h1;
  assign ent             = mem_q[ste_rbin_q[1:0]];
  assign wsync_busy      = (state_q == ste_pkg::ST_SYNC);

  // entries popped during a burst are dropped, not delayed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ste_rbin_q  <= 3'h0;
      ste_rgray_q <= 3'h0;
    end else if (!empty) begin // [RULE_14]
      ste_rbin_q  <= rbin_nx;
      ste_rgray_q <= rbin_nx ^ (rbin_nx >> 1);
    end
  end

  assign start_sync = (state_q == ste_pkg::ST_NORMAL) && !empty && !cfg_q[0] && !cfg_q[1] &&
                      ent[`STE_GRP_FV_BIT] && !ent[`STE_GRP_ERR_BIT] &&
                      ent[`STE_ENT_K_BIT] && (ent[7:0] == `STE_WSYNC_BYTE); // [RULE_13]
  // group 0 of the burst follows the pattern too, not the disparity
  assign start_pat  = running_disparity_q ? `STE_WSYNC_PAT_RDP : `STE_WSYNC_PAT_RDN; // [RULE_22]

  always_comb begin
    enc_out  = enc8b10b(ent[7:0], ent[`STE_ENT_K_BIT], running_disparity_q); // [RULE_10]
    next_out = enc8b10b(`STE_K28_5_BYTE, 1'b1, running_disparity_q); // [RULE_09]
    if (state_q == ste_pkg::ST_SYNC) begin
      next_out = burst_pat_q[burst_cnt_q] ? {1'b0, `STE_IDLE_RDP} : {1'b1, `STE_IDLE_RDN};
    end else if (start_sync) begin
      next_out = start_pat[0] ? {1'b0, `STE_IDLE_RDP} : {1'b1, `STE_IDLE_RDN};
    end else if (!empty && cfg_q[0]) begin
      next_out = {(($countones(ent[9:0]) != 5) ? !running_disparity_q : running_disparity_q),
                  ent[9:0]}; // [RULE_15] [RULE_16] [RULE_17]
    end else if (!empty && ent[`STE_GRP_FV_BIT]) begin
      if (ent[`STE_GRP_ERR_BIT])
        next_out = {running_disparity_q, `STE_ILLEGAL_GROUP}; // [RULE_12]
      else
        next_out = enc_out; // [RULE_11]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_group_q          <= 10'h000;
      running_disparity_q <= 1'b0;
    end else begin
      tx_group_q          <= next_out[9:0]; // [RULE_02]
      running_disparity_q <= next_out[10]; // [RULE_23]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q     <= ste_pkg::ST_NORMAL;
      burst_cnt_q <= 4'h0;
      burst_pat_q <= 16'h0000;
    end else begin
      unique case (state_q)
        ste_pkg::ST_NORMAL: begin
          if (start_sync) begin
            state_q     <= ste_pkg::ST_SYNC;
            burst_cnt_q <= 4'h1;
            burst_pat_q <= start_pat; // [RULE_22]
          end
        end
        ste_pkg::ST_SYNC: begin
          burst_cnt_q <= burst_cnt_q + 4'h1;
          if (burst_cnt_q == `STE_WSYNC_LAST)
            state_q <= ste_pkg::ST_NORMAL; // [RULE_14]
        end
      endcase
    end
  end
endmodule : ste_device
`default_nettype wire

/* File: ste_host.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ste_defines.svh"
module ste_host (
  input  wire logic  clk,
  input  wire logic  rst,
  ste_link_if.host   link,
  input  wire logic  coded_bypass_enable,
  input  wire logic  double_edge_select,
  input  wire logic  word_valid,
  output logic       word_ready,
  input  wire logic  [7:0] word_byte,
  input  wire logic  word_frame_valid,
  input  wire logic  word_error_force,
  input  wire logic  word_control_flag
);
  logic [1:0] div_q;
  logic [7:0] byte_q;
  logic       fv_q;
  logic       err_q;
  logic       k_q;
  logic       tx_clk_q;
  logic [7:0] pin_byte_q;
  logic       pin_fv_q;
  logic       pin_err_q;
  logic       pin_k_q;
  // coded idle is the whole ten-bit group, error and valid bits included
  localparam logic [9:0] IDLE_GRP = `STE_IDLE_RDN;

  // link clock is a quarter of clk; pins change one clk ahead of each rising link edge, and of each falling one in double-edge mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q    <= 2'h0;
      tx_clk_q <= 1'b0;
    end else begin
      div_q    <= div_q + 2'h1;
      tx_clk_q <= div_q[1]; // [RULE_07]
    end
  end

  assign link.tx_clk = tx_clk_q;
  assign word_ready  = (div_q == `STE_DIV_RISE_PHASE); // [RULE_08]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      byte_q <= 8'h00;
      fv_q   <= 1'b0;
      err_q  <= 1'b0;
      k_q    <= 1'b0;
    end else if (word_ready) begin
      if (word_valid) begin
        byte_q <= word_byte;
        fv_q   <= word_frame_valid;
        err_q  <= word_error_force;
        k_q    <= word_control_flag;
      end else if (coded_bypass_enable) begin
        byte_q <= IDLE_GRP[7:0]; // [RULE_18] [RULE_20]
        fv_q   <= IDLE_GRP[`STE_GRP_FV_BIT];
        err_q  <= IDLE_GRP[`STE_GRP_ERR_BIT];
        k_q    <= 1'b0;
      end else begin
        byte_q <= 8'h00;
        fv_q   <= 1'b0;
        err_q  <= 1'b0;
        k_q    <= 1'b0;
      end
    end
  end

  // pins are driven one clk after the word is taken, stable over the link edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_byte_q <= 8'h00;
      pin_fv_q   <= 1'b0;
      pin_err_q  <= 1'b0;
      pin_k_q    <= 1'b0;
    end else if (div_q == 2'h1) begin
      pin_err_q <= err_q;
      pin_k_q   <= k_q;
      if (double_edge_select) begin
        pin_byte_q <= {4'h0, byte_q[3:0]};
        pin_fv_q   <= coded_bypass_enable ? byte_q[4] : fv_q;
      end else begin
        pin_byte_q <= byte_q; // [RULE_16] [RULE_19] [RULE_21]
        pin_fv_q   <= fv_q;
      end
    end else if ((div_q == 2'h3) && double_edge_select) begin
      if (coded_bypass_enable) begin
        pin_byte_q <= {4'h0, fv_q, byte_q[7:5]};
        pin_fv_q   <= err_q;
      end else begin
        pin_byte_q <= {4'h0, byte_q[7:4]};
      end
    end
  end

  assign link.tx_byte         = pin_byte_q;
  assign link.tx_frame_valid  = pin_fv_q;
  assign link.tx_error_force  = pin_err_q;
  assign link.tx_control_flag = pin_k_q;
endmodule : ste_host
`default_nettype wire

/* File: ste_link_properties.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ste_defines.svh"
module ste_link_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       tx_clk,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_frame_valid,
  input wire logic       tx_error_force,
  input wire logic       tx_control_flag,
  input wire logic       ethernet_mode_select,
  input wire logic       coded_bypass_enable,
  input wire logic       double_edge_select,
  input wire logic [9:0] tx_group_q,
  input wire logic       running_disparity_q,
  input wire logic       wsync_busy
);
  wire logic [10:0] pins = {tx_byte, tx_frame_valid, tx_error_force, tx_control_flag};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_link_clk_shape: assert property ($rose(tx_clk) |=> tx_clk ##1 !tx_clk ##1 !tx_clk ##1 tx_clk)
    else $error("link clock not a divide by four");
  a_pins_hold_edge: assert property ($rose(tx_clk) |-> $stable(pins))
    else $error("link pins moved after rising edge");
  // setup margin: pins settle one cycle before the capturing edge
  a_pins_lead_edge: assert property ($changed(pins) |=> $changed(tx_clk))
    else $error("link pins changed away from an edge");
  a_ddr_upper_zero: assert property (double_edge_select |-> tx_byte[7:4] == 4'h0)
    else $error("upper nibble driven in double-edge mode");
  a_burst_length: assert property ($rose(wsync_busy) |->
    wsync_busy[*8] ##1 wsync_busy[*7] ##1 !wsync_busy)
    else $error("word-sync burst length wrong");
  a_burst_idle_only: assert property (wsync_busy |->
    tx_group_q inside {`STE_IDLE_RDN, `STE_IDLE_RDP})
    else $error("non-idle group inside burst");
  a_no_burst_mode: assert property (coded_bypass_enable || ethernet_mode_select |-> !wsync_busy)
    else $error("burst outside backplane uncoded mode");
  a_invalid_keeps_rd: assert property (tx_group_q == `STE_ILLEGAL_GROUP |->
    running_disparity_q == $past(running_disparity_q))
    else $error("disparity moved on balanced invalid group");
  // burst group 0 is excluded by the busy that is high in its own cycle
  a_idle_rd_update: assert property (!coded_bypass_enable && !wsync_busy &&
    tx_group_q inside {`STE_IDLE_RDN, `STE_IDLE_RDP} |=> wsync_busy ||
    ($past(running_disparity_q) == ($past(tx_group_q) == `STE_IDLE_RDN)))
    else $error("disparity not updated after idle");

  c_burst_start: cover property ($rose(wsync_busy));
  c_invalid_sent: cover property (tx_group_q == `STE_ILLEGAL_GROUP);
  c_ddr_fall: cover property (double_edge_select && $fell(tx_clk));
endmodule : ste_link_properties
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ste_defines.svh"
`define CHECK_EQ(got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  logic       clk, rst, shr, eth, cbe, ddr;
  logic       word_valid, word_ready, word_fv, word_err, word_k;
  logic [7:0] word_byte;
  logic [9:0] tx_group_q, last_grp;
  logic       running_disparity_q, wsync_busy;
  logic       rx_eth, rx_cod, ch0_clk;
  int         n_fail, check_count, busy_cnt, swap_cnt;
  logic [9:0] got_q[$];
  logic [9:0] exp_q[$];

  ste_link_if ste_link_if_inst ();
  // alternate capture clock stays quiet unless shared capture is selected
  assign ch0_clk = shr ? ste_link_if_inst.tx_clk : 1'b0;
  ste_host ste_host_inst (.clk(clk), .rst(rst), .link(ste_link_if_inst.host),
    .coded_bypass_enable(cbe), .double_edge_select(ddr), .word_valid(word_valid),
    .word_ready(word_ready), .word_byte(word_byte), .word_frame_valid(word_fv),
    .word_error_force(word_err), .word_control_flag(word_k));
  ste_device ste_device_inst (.clk(clk), .rst(rst), .link(ste_link_if_inst.device),
    .first_channel_tx_clk(ch0_clk), .shared_clk_select(shr),
    .ethernet_mode_select(eth), .coded_bypass_enable(cbe), .double_edge_select(ddr),
    .tx_group_q(tx_group_q), .running_disparity_q(running_disparity_q),
    .wsync_busy(wsync_busy), .rx_ethernet_cfg(rx_eth), .rx_coded_cfg(rx_cod));
  ste_link_properties ste_link_properties_inst (.clk(clk), .rst(rst),
    .tx_clk(ste_link_if_inst.tx_clk), .tx_byte(ste_link_if_inst.tx_byte),
    .tx_frame_valid(ste_link_if_inst.tx_frame_valid),
    .tx_error_force(ste_link_if_inst.tx_error_force),
    .tx_control_flag(ste_link_if_inst.tx_control_flag), .ethernet_mode_select(eth),
    .coded_bypass_enable(cbe), .double_edge_select(ddr), .tx_group_q(tx_group_q),
    .running_disparity_q(running_disparity_q), .wsync_busy(wsync_busy));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // both disparity forms of D0.0 and K28.1 compare as one
  function automatic logic [9:0] fold_rd(input logic [9:0] g);
    case (g)
      10'h18B: return 10'h274;
      10'h306: return 10'h0F9;
      default: return g;
    endcase
  endfunction : fold_rd

  always @(negedge clk) begin
    if (!rst && !(tx_group_q inside {`STE_IDLE_RDN, `STE_IDLE_RDP, 10'h000})) begin
      got_q.push_back(fold_rd(tx_group_q));
    end
    if (!rst && wsync_busy === 1'b1) begin
      if (busy_cnt > 0 && tx_group_q !== last_grp) swap_cnt++;
      busy_cnt++;
      last_grp = tx_group_q;
    end
  end

  task test_done;
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // mode pins only change under reset, they pass synchronisers
  task restart(input logic e, input logic c, input logic d, input logic s);
    @(negedge clk);
    rst = 1'b1;
    eth = e;
    cbe = c;
    ddr = d;
    shr = s;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    // link clock is held in reset, so the link side mode syncs need a few link edges
    repeat (16) @(negedge clk);
    `CHECK_EQ(rx_eth, e)
    `CHECK_EQ(rx_cod, c)
    got_q.delete();
    busy_cnt = 0;
    swap_cnt = 0;
  endtask : restart

  task send(input logic [7:0] b, input logic fv, input logic err, input logic k);
    int  i;
    logic took;
    took = 1'b0;
    for (i = 0; i < 8 && !took; i++) begin
      @(negedge clk);
      word_byte = b;
      word_fv = fv;
      word_err = err;
      word_k = k;
      word_valid = 1'b1;
      if (word_ready === 1'b1) begin
        @(posedge clk);
        took = 1'b1;
      end
    end
    @(negedge clk);
    word_valid = 1'b0;
    if (!took) begin
      n_fail++;
      test_done();
    end
  endtask : send

  // drain wait covers fifo crossing plus a full burst
  task expect_words;
    repeat (40) @(negedge clk);
    `CHECK_EQ(got_q.size(), exp_q.size())
    foreach (exp_q[i]) if (i < got_q.size()) `CHECK_EQ(got_q[i], exp_q[i])
    exp_q.delete();
    got_q.delete();
  endtask : expect_words

  initial begin
    rst = 1'b1;
    {shr, eth, cbe, ddr, word_valid, word_fv, word_err, word_k} = 8'h00;
    word_byte = 8'h00;
    n_fail = 0;
    check_count = 0;
    restart(1'b0, 1'b0, 1'b0, 1'b0);
    send(8'h00, 1'b1, 1'b0, 1'b0);
    exp_q.push_back(10'h274);
    send(8'h00, 1'b1, 1'b1, 1'b1);
    exp_q.push_back(`STE_ILLEGAL_GROUP);
    send(8'h00, 1'b1, 1'b0, 1'b1);
    exp_q.push_back(`STE_ILLEGAL_GROUP);
    send(8'h3C, 1'b1, 1'b0, 1'b1);
    exp_q.push_back(10'h0F9);
    send(`STE_WSYNC_BYTE, 1'b0, 1'b1, 1'b1);
    expect_words();
    send(`STE_WSYNC_BYTE, 1'b1, 1'b0, 1'b1);
    send(8'h00, 1'b1, 1'b1, 1'b0);
    send(8'h00, 1'b1, 1'b1, 1'b0);
    expect_words();
    `CHECK_EQ(busy_cnt, 15)
    `CHECK_EQ(swap_cnt, 1)
    send(8'h00, 1'b1, 1'b0, 1'b0);
    exp_q.push_back(10'h274);
    expect_words();
    restart(1'b0, 1'b1, 1'b0, 1'b1);
    send(8'h55, 1'b1, 1'b1, 1'b1);
    exp_q.push_back(10'h355);
    send(8'h0F, 1'b0, 1'b1, 1'b0);
    exp_q.push_back(10'h20F);
    send(`STE_WSYNC_BYTE, 1'b1, 1'b0, 1'b1);
    exp_q.push_back(10'h1AD);
    expect_words();
    `CHECK_EQ(busy_cnt, 0)
    restart(1'b0, 1'b0, 1'b1, 1'b0);
    send(8'h00, 1'b1, 1'b0, 1'b0);
    exp_q.push_back(10'h274);
    send(8'h00, 1'b1, 1'b1, 1'b0);
    exp_q.push_back(`STE_ILLEGAL_GROUP);
    expect_words();
    restart(1'b1, 1'b1, 1'b1, 1'b1);
    send(8'h55, 1'b1, 1'b1, 1'b0);
    exp_q.push_back(10'h355);
    expect_words();
    restart(1'b1, 1'b0, 1'b0, 1'b0);
    send(`STE_WSYNC_BYTE, 1'b1, 1'b0, 1'b1);
    repeat (40) @(negedge clk);
    `CHECK_EQ(busy_cnt, 0)
    test_done();
  end
endmodule : testbench
`default_nettype wire
